//--- rtl/asr_pkg.sv
// Purpose: Shared constants and types for the async serial receiver
// Assumes: 50 MHz system clock, 8-bit low-speed divisor mode
// Notes: Register offsets are word indices on the plain register port
package asr_pkg;
	// ==========================================
	// Register map
	localparam logic [1:0] ASR_OFF_CTRL = 2'h0;
	localparam logic [1:0] ASR_OFF_STAT = 2'h1;
	localparam logic [1:0] ASR_OFF_DATA = 2'h2;
	localparam logic [1:0] ASR_OFF_BAUD = 2'h3;
	// Control field positions
	localparam int ASR_CTL_PORT_EN = 0;
	localparam int ASR_CTL_RCV_EN = 1;
	localparam int ASR_CTL_NINE = 2;
	localparam int ASR_CTL_ADDR_DET = 3;
	// Status field positions
	localparam int ASR_ST_FRAME_ERR = 0;
	localparam int ASR_ST_OVERRUN = 1;
	localparam int ASR_ST_NINTH = 2;
	localparam int ASR_ST_DATA_RDY = 3;
	// Reset values
	localparam logic [3:0] ASR_CTRL_RST = 4'h0;
	localparam logic [7:0] ASR_BAUD_RST = 8'h00;
	// Oversampling: bit time is 64 clocks times (divisor + 1)
	localparam int ASR_BAUD_MULT = 64;
	localparam int ASR_PRE_W = 6;
	localparam logic [5:0] ASR_PRE_LAST = 6'h3f;
	localparam logic [5:0] ASR_PRE_HALF = 6'h1f;
	localparam logic [3:0] ASR_NBITS8 = 4'h8;
	localparam logic [3:0] ASR_NBITS9 = 4'h9;
	localparam int ASR_FIFO_DEPTH = 2;

	typedef enum logic [1:0]
	{
		ASR_IDLE = 2'b00,
		ASR_START = 2'b01,
		ASR_DATA = 2'b11,
		ASR_STOP = 2'b10
	} asr_state_t;

	// One FIFO entry: data plus its own framing flag
	typedef struct packed
	{
		logic frame_err;
		logic [8:0] data;
	} asr_char_t;
endpackage

//--- rtl/asr_rx.sv
// Purpose: Async serial receiver with two-deep FIFO, framing/overrun status, 9-bit and address detect
// Assumes: Software uses the plain register port; line idles high
// Notes: Bit time is 64 x (divisor + 1) system clocks, samples at mid bit
//
// Added by the designer: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module asr_rx
	import asr_pkg::*;
#(
	parameter int DEPTH = ASR_FIFO_DEPTH
)
(
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic [1:0] i_addr,
	input wire logic [8:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic i_rx,
	output logic [8:0] o_rdata,
	output logic o_rcv_flag
);

	// ==========================================
	// Elaboration check
	// Slot indexing uses a single count bit, so only two entries fit
	if (DEPTH != ASR_FIFO_DEPTH)
	begin : g_bad_depth
		$error("asr_rx supports a two-entry FIFO only");
	end

	// ==========================================
	// Line synchroniser
	logic rx_s1_r;
	logic rx_s2_r;
	logic rx_s3_r;
	// Two stages before use; third stage only for edge detect
	always_ff @(posedge i_clk)
	begin
		if (!i_resetn)
		begin
			rx_s1_r <= 1'b1;
			rx_s2_r <= 1'b1;
			rx_s3_r <= 1'b1;
		end
		else
		begin
			rx_s1_r <= i_rx;
			rx_s2_r <= rx_s1_r;
			rx_s3_r <= rx_s2_r;
		end
	end

	// ==========================================
	// Control registers
	logic [3:0] ctrl_r;
	logic [3:0] ctrl_nxt;
	logic [7:0] baud_r;
	logic [7:0] baud_nxt;
	logic port_en;
	logic rcv_en;
	logic nine_sel;
	logic addr_det;
	// Enable bits decoded once so every user sees the same level
	assign port_en = ctrl_r[ASR_CTL_PORT_EN];
	assign rcv_en = ctrl_r[ASR_CTL_RCV_EN];
	assign nine_sel = ctrl_r[ASR_CTL_NINE];
	assign addr_det = ctrl_r[ASR_CTL_ADDR_DET];

	// Software writes to control and divisor
	always_comb
	begin
		ctrl_nxt = ctrl_r;
		baud_nxt = baud_r;
		if (i_wr && i_addr == ASR_OFF_CTRL)
			ctrl_nxt = i_wdata[3:0];
		if (i_wr && i_addr == ASR_OFF_BAUD)
			baud_nxt = i_wdata[7:0];
	end

	// Reset leaves the port disabled until software enables it
	always_ff @(posedge i_clk)
	begin
		if (!i_resetn)
		begin
			ctrl_r <= ASR_CTRL_RST;
			baud_r <= ASR_BAUD_RST;
		end
		else
		begin
			ctrl_r <= ctrl_nxt;
			baud_r <= baud_nxt;
		end
	end

	// ==========================================
	// Receive state machine
	asr_state_t st_r;
	asr_state_t st_nxt;
	logic [ASR_PRE_W-1:0] pre_r;
	logic [ASR_PRE_W-1:0] pre_nxt;
	logic [7:0] div_r;
	logic [7:0] div_nxt;
	logic [3:0] bit_r;
	logic [3:0] bit_nxt;
	logic [8:0] shift_r;
	logic [8:0] shift_nxt;
	logic done;
	logic done_frame_err;
	logic tick;
	logic [3:0] nbits;
	// A tick is one full bit time: 64 prescale steps times (divisor + 1)
	// Integer divisor only, so some rates carry a small error against the nominal baud
	assign tick = (pre_r == ASR_PRE_LAST) && (div_r == baud_r);
	assign nbits = nine_sel ? ASR_NBITS9 : ASR_NBITS8;

	// Receiver runs while the port and continuous receive are enabled
	always_comb
	begin
		st_nxt = st_r;
		pre_nxt = pre_r;
		div_nxt = div_r;
		bit_nxt = bit_r;
		shift_nxt = shift_r;
		done = 1'b0;
		done_frame_err = 1'b0;
		if (st_r != ASR_IDLE)
		begin
			if (pre_r == ASR_PRE_LAST)
			begin
				pre_nxt = '0;
				div_nxt = (div_r == baud_r) ? 8'h00 : div_r + 8'h01;
			end
			else
				pre_nxt = pre_r + 6'h01;
		end
		case (st_r)
			ASR_IDLE:
			begin
				// Start offset by half a bit so later ticks land mid bit
				if (port_en && rcv_en && rx_s3_r && !rx_s2_r)
				begin
					st_nxt = ASR_START;
					// Half a bit is 32 x (divisor + 1) clocks; odd divisors begin at a prescale turn end
					pre_nxt = baud_r[0] ? ASR_PRE_LAST : ASR_PRE_HALF;
					div_nxt = {1'b0, baud_r[7:1]};
				end
			end
			ASR_START:
			begin
				// Check start at its middle; a glitch returns to idle
				if (tick)
				begin
					if (rx_s2_r)
						st_nxt = ASR_IDLE;
					else
					begin
						st_nxt = ASR_DATA;
						bit_nxt = 4'h0;
					end
				end
			end
			ASR_DATA:
			begin
				if (tick)
				begin
					// LSB first; the ninth bit lands in the top position
					shift_nxt = nine_sel ? {rx_s2_r, shift_r[8:1]} : {1'b0, rx_s2_r, shift_r[7:1]};
					bit_nxt = bit_r + 4'h1;
					if (bit_r + 4'h1 == nbits)
						st_nxt = ASR_STOP;
				end
			end
			ASR_STOP:
			begin
				if (tick)
				begin
					// Stop sampled mid bit; low means framing error
					done = 1'b1;
					done_frame_err = !rx_s2_r;
					st_nxt = ASR_IDLE;
				end
			end
			default:
				st_nxt = ASR_IDLE;
		endcase
		if (!port_en || !rcv_en)
			st_nxt = ASR_IDLE;
	end

	// Receiver state only; the FIFO keeps its own registers below
	always_ff @(posedge i_clk)
	begin
		if (!i_resetn)
		begin
			st_r <= ASR_IDLE;
			pre_r <= '0;
			div_r <= 8'h00;
			bit_r <= 4'h0;
			shift_r <= 9'h000;
		end
		else
		begin
			st_r <= st_nxt;
			pre_r <= pre_nxt;
			div_r <= div_nxt;
			bit_r <= bit_nxt;
			shift_r <= shift_nxt;
		end
	end

	// ==========================================
	// Two-entry FIFO and error flags
	asr_char_t fifo_r [DEPTH];
	asr_char_t fifo_nxt [DEPTH];
	logic [1:0] cnt_r;
	logic [1:0] cnt_nxt;
	logic overrun_r;
	logic overrun_nxt;
	logic pop;
	logic push;
	logic keep;
	// A read of an empty FIFO is refused and leaves the count alone
	assign pop = i_rd && (i_addr == ASR_OFF_DATA) && (cnt_r != 2'h0);
	// In 9-bit mode, address detect drops characters with a clear ninth bit
	assign keep = !(addr_det && nine_sel && !shift_r[8]) && !overrun_r;
	assign push = done && keep;

	always_comb
	begin
		fifo_nxt = fifo_r;
		cnt_nxt = cnt_r;
		overrun_nxt = overrun_r;
		if (pop)
		begin
			fifo_nxt[0] = fifo_r[1];
			cnt_nxt = cnt_r - 2'h1;
		end
		if (push)
		begin
			// A pop in the same cycle frees a slot, so no overrun then
			if (cnt_nxt == 2'h2)
				overrun_nxt = 1'b1;
			else
			begin
				fifo_nxt[cnt_nxt[0]] = '{frame_err: done_frame_err, data: shift_r};
				cnt_nxt = cnt_nxt + 2'h1;
			end
		end
		// Only enable clears end an overrun; clearing receive keeps FIFO
		if (!rcv_en)
			overrun_nxt = 1'b0;
		if (!port_en)
		begin
			// Port disable empties the FIFO and clears overrun, framing flags included
			overrun_nxt = 1'b0;
			cnt_nxt = 2'h0;
			for (int k = 0; k < DEPTH; k++)
				fifo_nxt[k] = '0;
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_resetn)
		begin
			for (int k = 0; k < DEPTH; k++)
				fifo_r[k] <= '0;
			cnt_r <= 2'h0;
			overrun_r <= 1'b0;
		end
		else
		begin
			fifo_r <= fifo_nxt;
			cnt_r <= cnt_nxt;
			overrun_r <= overrun_nxt;
		end
	end

	// ==========================================
	// Read port and receive flag
	logic [8:0] rdata_nxt;
	logic rcv_flag_nxt;
	logic [8:0] stat_word;
	// Framing and ninth status bits reflect only the head entry; writes cannot touch it
	always_comb
	begin
		stat_word = 9'h000;
		stat_word[ASR_ST_FRAME_ERR] = (cnt_r != 2'h0) && fifo_r[0].frame_err;
		stat_word[ASR_ST_OVERRUN] = overrun_r;
		stat_word[ASR_ST_NINTH] = (cnt_r != 2'h0) && fifo_r[0].data[8];
		stat_word[ASR_ST_DATA_RDY] = (cnt_r != 2'h0);
	end

	always_comb
	begin
		rdata_nxt = 9'h000;
		if (i_rd)
		begin
			case (i_addr)
				ASR_OFF_CTRL: rdata_nxt = {5'h00, ctrl_r};
				ASR_OFF_STAT: rdata_nxt = stat_word;
				// An empty FIFO reads as zero rather than a stale entry
				ASR_OFF_DATA: rdata_nxt = (cnt_r != 2'h0) ? {1'b0, fifo_r[0].data[7:0]} : 9'h000;
				ASR_OFF_BAUD: rdata_nxt = {1'b0, baud_r};
				default: rdata_nxt = 9'h000;
			endcase
		end
		// Interrupt tracks data presence only, never framing errors
		rcv_flag_nxt = (cnt_nxt != 2'h0);
	end

	// Both outputs leave straight from flops
	always_ff @(posedge i_clk)
	begin
		if (!i_resetn)
		begin
			o_rdata <= 9'h000;
			o_rcv_flag <= 1'b0;
		end
		else
		begin
			o_rdata <= rdata_nxt;
			o_rcv_flag <= rcv_flag_nxt;
		end
	end

endmodule

//--- testbench/asr_rx_sva.sv
// Purpose: Port checks for the serial receiver
// Assumes: One clock, synchronous active-low reset
// Notes: Line-quiet bound holds for divisors up to 5
`timescale 1ns/1ps
module asr_rx_sva
	import asr_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic [1:0] i_addr,
	input wire logic [8:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic i_rx,
	input wire logic [8:0] o_rdata,
	input wire logic o_rcv_flag
);
	logic [11:0] quiet_r;
	logic [11:0] quiet_nxt;
	logic off_w;
	// ==========
	// Helpers: port-disable write, cycles since line was low
	assign off_w = i_wr && i_addr == ASR_OFF_CTRL && !i_wdata[ASR_CTL_PORT_EN];
	always_comb
	begin
		quiet_nxt = (!i_resetn || !i_rx) ? 12'h000 : quiet_r + {11'h000, quiet_r != 12'hfff};
	end
	always_ff @(posedge i_clk)
	begin
		quiet_r <= quiet_nxt;
	end
	// ==========
	// Properties
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_resetn);
	sequence s_rd_data;
		i_rd && i_addr == ASR_OFF_DATA;
	endsequence
	sequence s_rd_stat;
		i_rd && i_addr == ASR_OFF_STAT;
	endsequence
	a_rdata_quiet: assert property (o_rdata != 9'h000 |-> $past(i_rd))
		else $error("read data outside slot");
	a_stat_flag: assert property (s_rd_stat |=> o_rdata[ASR_ST_DATA_RDY] == $past(o_rcv_flag))
		else $error("status flag differs");
	a_stat_top: assert property (s_rd_stat |=> o_rdata[8:4] == 5'h00)
		else $error("status upper bits set");
	a_data_top: assert property (s_rd_data |=> !o_rdata[8])
		else $error("data bit 8 set");
	a_empty_read: assert property (s_rd_data ##0 !o_rcv_flag |=> o_rdata == 9'h000)
		else $error("empty read not zero");
	a_port_flush: assert property (off_w |-> ##3 !o_rcv_flag)
		else $error("port off kept data");
	a_drop_cause: assert property ($fell(o_rcv_flag) |-> $past(i_rd && i_addr == ASR_OFF_DATA)
		|| $past(off_w) || $past(off_w, 2) || $past(off_w, 3))
		else $error("flag fell without cause");
	// A push needs a start bit not long before
	a_push_start: assert property ($rose(o_rcv_flag) |-> quiet_r != 12'hfff)
		else $error("push without frame");
endmodule
bind asr_rx asr_rx_sva u_sva (.i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
	.i_wr(i_wr), .i_rd(i_rd), .i_rx(i_rx), .o_rdata(o_rdata), .o_rcv_flag(o_rcv_flag));

//--- testbench/asr_line_model.sv
// Purpose: Remote transmitter on the shared line
// Assumes: Line idles high between frames
// Notes: Bit time in clocks is given per frame
`timescale 1ns/1ps
module asr_line_model
(
	input wire logic i_clk,
	output logic o_line
);
	// ==========
	// Start low, data LSB first, stop, then one idle bit so the next start edge is seen
	initial o_line = 1'b1;
	task automatic send(input logic [8:0] d, input int nb, input int bt, input logic stop);
		for (int i = 0; i < nb + 3; i++)
		begin
			@(posedge i_clk);
			o_line <= (i == 0) ? 1'b0 : (i <= nb) ? d[i - 1] : (i == nb + 1) ? stop : 1'b1;
			repeat (bt - 1) @(posedge i_clk);
		end
	endtask
endmodule

//--- testbench/testbench.sv
// Purpose: Self-checking bench for the serial receiver
// Assumes: Small divisors keep frames short
// Notes: Table rows, then overrun, port reset, address filter
`timescale 1ns/1ps
module testbench;
	import asr_pkg::*;
	logic i_clk;
	logic i_resetn;
	logic [1:0] i_addr;
	logic [8:0] i_wdata;
	logic i_wr;
	logic i_rd;
	logic rx_line;
	logic [8:0] o_rdata;
	logic o_rcv_flag;
	logic [25:0] rows[4];
	logic [3:0] c;
	logic [7:0] dv;
	logic [8:0] d;
	logic sb;
	logic [3:0] st;
	int n_errors;
	int checked;
	int cyc;
	asr_rx dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
		.i_rd(i_rd), .i_rx(rx_line), .o_rdata(o_rdata), .o_rcv_flag(o_rcv_flag));
	asr_line_model line (.i_clk(i_clk), .o_line(rx_line));
	// ==========
	// Clock and watchdog
	initial
	begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end
	always @(posedge i_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			n_errors = n_errors + 1;
			end_sim();
		end
	end
	// ==========
	// Tasks
	task automatic chk(input string n, input logic [8:0] s, input logic [8:0] e);
		checked++;
		if (s !== e)
		begin
			n_errors++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [1:0] a, input logic [8:0] v);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= v;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask
	// Read data stands only in the cycle after the strobe
	task automatic rc(input logic [1:0] a, input logic [8:0] e);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1;
		chk($sformatf("reg %0d", a), o_rdata, e);
	endtask
	task automatic end_sim();
		$display("checked %0d n_errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// ==========
	// Main sequence
	initial
	begin
		cyc = 0;
		n_errors = 0;
		checked = 0;
		i_resetn = 1'b0;
		i_addr = 2'h0;
		i_wdata = 9'h000;
		i_wr = 1'b0;
		i_rd = 1'b0;
		// Control, divisor, character, stop level, expected status
		rows[0] = {4'h3, 8'h00, 9'h0a5, 1'b1, 4'h8};
		rows[1] = {4'h3, 8'h02, 9'h05a, 1'b0, 4'h9};
		rows[2] = {4'h7, 8'h00, 9'h13c, 1'b1, 4'hc};
		rows[3] = {4'h7, 8'h01, 9'h0c3, 1'b1, 4'h8};
		repeat (3) @(posedge i_clk);
		i_resetn <= 1'b1;
		rc(ASR_OFF_CTRL, 9'h000);
		rc(ASR_OFF_BAUD, 9'h000);
		rc(ASR_OFF_STAT, 9'h000);
		chk("flag", {8'h00, o_rcv_flag}, 9'h000);
		wr(ASR_OFF_BAUD, 9'h019);
		rc(ASR_OFF_BAUD, 9'h019);
		$display("reset done");
		foreach (rows[k])
		begin
			{c, dv, d, sb, st} = rows[k];
			wr(ASR_OFF_CTRL, {5'h00, c});
			wr(ASR_OFF_BAUD, {1'b0, dv});
			line.send(d, c[ASR_CTL_NINE] ? 9 : 8, ASR_BAUD_MULT * (dv + 1), sb);
			rc(ASR_OFF_STAT, {5'h00, st});
			chk("flag", {8'h00, o_rcv_flag}, 9'h001);
			rc(ASR_OFF_DATA, {1'b0, d[7:0]});
			rc(ASR_OFF_STAT, 9'h000);
			chk("flag", {8'h00, o_rcv_flag}, 9'h000);
			$display("row %0d done", k);
		end
		// Overrun: third whole character while full, then a fourth
		wr(ASR_OFF_BAUD, 9'h000);
		wr(ASR_OFF_CTRL, 9'h003);
		line.send(9'h011, 8, 64, 1'b0);
		line.send(9'h022, 8, 64, 1'b1);
		line.send(9'h033, 8, 64, 1'b1);
		line.send(9'h044, 8, 64, 1'b1);
		rc(ASR_OFF_STAT, 9'h00b);
		rc(ASR_OFF_DATA, 9'h011);
		rc(ASR_OFF_STAT, 9'h00a);
		wr(ASR_OFF_CTRL, 9'h001);
		rc(ASR_OFF_STAT, 9'h008);
		rc(ASR_OFF_DATA, 9'h022);
		rc(ASR_OFF_STAT, 9'h000);
		$display("overrun done");
		// Receive-enable clear keeps framing flag, port-enable clear drops it
		wr(ASR_OFF_CTRL, 9'h003);
		line.send(9'h055, 8, 64, 1'b0);
		wr(ASR_OFF_CTRL, 9'h001);
		rc(ASR_OFF_STAT, 9'h009);
		wr(ASR_OFF_CTRL, 9'h000);
		rc(ASR_OFF_STAT, 9'h000);
		$display("port reset done");
		// Address filter drops ninth-bit-zero characters until cleared
		wr(ASR_OFF_CTRL, 9'h00f);
		line.send(9'h055, 9, 64, 1'b1);
		line.send(9'h1a5, 9, 64, 1'b1);
		rc(ASR_OFF_STAT, 9'h00c);
		rc(ASR_OFF_DATA, 9'h0a5);
		wr(ASR_OFF_CTRL, 9'h007);
		line.send(9'h033, 9, 64, 1'b1);
		rc(ASR_OFF_DATA, 9'h033);
		$display("address done");
		end_sim();
	end
endmodule
